/* logic/lcd_cmd_params.svh */
`ifndef LCD_CMD_PARAMS_SVH
`define LCD_CMD_PARAMS_SVH
// ===================================================
// command groups
`define GRP_GENERAL 2'h0
`define GRP_DATA 2'h1
`define GRP_DISPLAY 2'h2
`define GRP_PUMP 2'h3
// ===================================================
// general group command codes
`define CODE_INIT 8'h01
`define CODE_CLEAR_FLAG 8'h1f
`define CODE_OTP_REFRESH 8'h02
`define HEAD_CLOCK_OUT 7'h10
`define HEAD_READ_SELECT 6'h01
`define HEAD_MUX_MODE 5'h0a
`define HEAD_BANK_SEL 5'h02
`define ADDR_LOAD_BIT 7
// ===================================================
// display group command heads
`define HEAD_ENTRY_MODE 6'h0a
`define HEAD_INVERSION 5'h08
`define HEAD_FRAME_RATE 3'h4
`define HEAD_DISPLAY_CTRL 5'h04
`define HEAD_DISPLAY_CFG 6'h01
// ===================================================
// pump and compensation group command heads
`define HEAD_PUMP_CTRL 5'h10
`define HEAD_LCD_VOLTAGE_VALUE_HIGH 3'h5
`define HEAD_LCD_VOLTAGE_VALUE_LOW 4'h9
`define HEAD_TEMP_CTRL 5'h00
`define HEAD_SLOPE_A 5'h01
`define HEAD_SLOPE_B 5'h02
`define HEAD_SLOPE_C 5'h03
`define HEAD_SLOPE_D 5'h04
// ===================================================
// reset values and readout layout
`define RST_MUX_RATIO 1'b1
`define RST_STEP_UP 1'b1
`define RST_FRAME_RATE 5'h07
`define RST_SUM 8'h00
`define RST_FLAG 1'b1
`define BANK_GP1 3'h0
`define BANK_GP2 3'h4
`define LAST_ENTRY 4'h9
`define CRC_POLY_DEFAULT 8'h07
`endif

/* logic/lcd_cmd_pkg.sv */
`default_nettype none
package lcd_cmd_pkg;
   // ===================================================
   // one command byte as delivered by the bus framing
   typedef struct packed {
      logic rw;
      logic [1:0] command_group;
      logic [7:0] data;
   } cmd_t;
   // ===================================================
   // all settings held by the command decoder
   typedef struct packed {
      logic mux_ratio_sel;
      logic step_up;
      logic [2:0] inversion_sel;
      logic [4:0] frame_rate_sel;
      logic display_on;
      logic mirror;
      logic pump_enable;
      logic [1:0] multiplier_sel;
      logic [8:0] lcd_voltage_value;
      logic tempcomp_enable;
      logic measure_filter;
      logic measure_enable;
      logic [2:0] slope_a;
      logic [2:0] slope_b;
      logic [2:0] slope_c;
      logic [2:0] slope_d;
      logic clock_out_enable;
      logic sum_kind;
      logic readout_status;
      logic [2:0] bank_sel;
   } settings_t;
endpackage : lcd_cmd_pkg
`default_nettype wire

/* logic/lcd_status_and_ram_access.sv */
`timescale 1ns/1ns
`default_nettype none
`include "lcd_cmd_params.svh"

module lcd_status_and_ram_access
   import lcd_cmd_pkg::*;
#(
   parameter int DEPTH = 128,
   parameter logic [7:0] CRC_POLY = `CRC_POLY_DEFAULT
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic frame_start,
   input wire logic cmd_valid,
   input wire cmd_t cmd,
   input wire logic [7:0] temperature_value,
   input wire logic pump_reached_pin,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output settings_t settings,
   output logic [6:0] ram_addr,
   output logic reset_seen_flag
);

   // ===================================================
   // decode
   settings_t settings_q;
   settings_t settings_d;
   settings_t settings_rst;
   logic [7:0] b;
   logic wr_gen;
   logic wr_disp;
   logic wr_pump;
   logic do_init;
   logic do_clear;
   logic do_write;
   logic do_read_data;
   logic do_read_status;
   logic do_addr_load;

   assign b = cmd.data;
   assign wr_gen = cmd_valid && !cmd.rw && (cmd.command_group == `GRP_GENERAL);
   assign wr_disp = cmd_valid && !cmd.rw && (cmd.command_group == `GRP_DISPLAY);
   assign wr_pump = cmd_valid && !cmd.rw && (cmd.command_group == `GRP_PUMP);
   assign do_init = wr_gen && (b == `CODE_INIT);
   assign do_clear = wr_gen && (b == `CODE_CLEAR_FLAG);
   assign do_addr_load = wr_gen && b[`ADDR_LOAD_BIT];
   assign do_write = cmd_valid && !cmd.rw && (cmd.command_group == `GRP_DATA);
   assign do_read_data = cmd_valid && cmd.rw && (cmd.command_group == `GRP_DATA);
   assign do_read_status = cmd_valid && cmd.rw && (cmd.command_group == `GRP_GENERAL);

   always_comb
   begin
      settings_rst = '0;
      settings_rst.mux_ratio_sel = `RST_MUX_RATIO;
      settings_rst.step_up = `RST_STEP_UP;
      settings_rst.frame_rate_sel = `RST_FRAME_RATE;
      settings_rst.bank_sel = `BANK_GP1;
   end

   // ===================================================
   // setting commands
   always_comb
   begin
      settings_d = settings_q;
      if (wr_gen)
      begin
         if (b[7:1] == `HEAD_CLOCK_OUT)
            settings_d.clock_out_enable = b[0];
         if (b[7:2] == `HEAD_READ_SELECT)
         begin
            settings_d.sum_kind = b[1];
            settings_d.readout_status = b[0];
         end
         if (b[7:3] == `HEAD_MUX_MODE)
            settings_d.mux_ratio_sel = b[2];
         if (b[7:3] == `HEAD_BANK_SEL)
            settings_d.bank_sel = b[2:0];
      end
      if (wr_disp)
      begin
         if (b[7:2] == `HEAD_ENTRY_MODE)
            settings_d.step_up = b[1];
         if (b[7:3] == `HEAD_INVERSION)
            settings_d.inversion_sel = b[2:0];
         if (b[7:5] == `HEAD_FRAME_RATE)
            settings_d.frame_rate_sel = b[4:0];
         if (b[7:3] == `HEAD_DISPLAY_CTRL)
            settings_d.display_on = b[2];
         if (b[7:2] == `HEAD_DISPLAY_CFG)
            settings_d.mirror = b[1];
      end
      if (wr_pump)
      begin
         if (b[7:3] == `HEAD_PUMP_CTRL)
         begin
            settings_d.pump_enable = b[2];
            settings_d.multiplier_sel = b[1:0];
         end
         if (b[7:5] == `HEAD_LCD_VOLTAGE_VALUE_HIGH)
            settings_d.lcd_voltage_value[8:4] = b[4:0];
         if (b[7:4] == `HEAD_LCD_VOLTAGE_VALUE_LOW)
            settings_d.lcd_voltage_value[3:0] = b[3:0];
         if (b[7:3] == `HEAD_TEMP_CTRL)
         begin
            settings_d.tempcomp_enable = b[2];
            settings_d.measure_filter = b[1];
            settings_d.measure_enable = b[0];
         end
         if (b[7:3] == `HEAD_SLOPE_A)
            settings_d.slope_a = b[2:0];
         if (b[7:3] == `HEAD_SLOPE_B)
            settings_d.slope_b = b[2:0];
         if (b[7:3] == `HEAD_SLOPE_C)
            settings_d.slope_c = b[2:0];
         if (b[7:3] == `HEAD_SLOPE_D)
            settings_d.slope_d = b[2:0];
      end
      if (do_init)
         settings_d = settings_rst;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         settings_q <= '0;
         settings_q.mux_ratio_sel <= `RST_MUX_RATIO;
         settings_q.step_up <= `RST_STEP_UP;
         settings_q.frame_rate_sel <= `RST_FRAME_RATE;
      end
      else
         settings_q <= settings_d;
   end

   // ===================================================
   // reset flag: init wins as it is a reset
   logic flag_q;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         flag_q <= `RST_FLAG;
      else if (do_init)
         flag_q <= 1'b1;
      else if (do_clear)
         flag_q <= 1'b0;
   end

   // ===================================================
   // pump reached input: three stages, accept when last two agree
   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic pump_reached_q;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         pump_reached_q <= 1'b0;
      end
      else
      begin
         sync1_q <= pump_reached_pin;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         if (sync2_q == sync3_q)
            pump_reached_q <= sync3_q;
      end
   end

   // ===================================================
   // checksum over written data
   logic [7:0] sum_q;
   logic [7:0] crc_next;

   always_comb
   begin
      crc_next = sum_q ^ b;
      for (int i = 0; i < 8; i++)
      begin
         if (crc_next[7])
            crc_next = {crc_next[6:0], 1'b0} ^ CRC_POLY;
         else
            crc_next = {crc_next[6:0], 1'b0};
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         sum_q <= `RST_SUM;
      else if (do_init)
         sum_q <= `RST_SUM;
      else if (do_write)
         sum_q <= settings_q.sum_kind ? crc_next : (sum_q ^ b);
   end

   // ===================================================
   // address counter
   logic [6:0] addr_q;
   logic [6:0] addr_step;

   assign addr_step = settings_q.step_up ? (addr_q + 7'h01) : (addr_q - 7'h01);

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         addr_q <= '0;
      else if (do_init)
         addr_q <= '0;
      else if (do_addr_load)
         addr_q <= b[6:0];
      else if (do_write || do_read_data)
         addr_q <= addr_step;
   end

   // ===================================================
   // memories: wide general ram and four narrow banks
   logic [7:0] ram_wide_q [DEPTH];
   logic [4:0] ram_narrow_q [4][DEPTH];
   logic [4:0] narrow_rd [4];

   always_ff @(posedge mclk)
   begin
      if (do_write && settings_q.bank_sel == `BANK_GP1)
         ram_wide_q[addr_q] <= b;
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_bank
         always_ff @(posedge mclk)
         begin
            // upper three bits are dropped; host keeps them zero
            if (do_write && settings_q.bank_sel == 3'(g + 1))
               ram_narrow_q[g][addr_q] <= b[4:0];
         end
         assign narrow_rd[g] = ram_narrow_q[g][addr_q];
      end
   endgenerate

   // ===================================================
   // status readout entries
   logic [3:0] entry_q;
   logic [7:0] entry_byte;

   always_comb
   begin
      case (entry_q)
         4'h0: entry_byte = sum_q;
         4'h1: entry_byte = {1'b0, settings_q.mux_ratio_sel, 2'b00, settings_q.step_up, 3'b000};
         4'h2: entry_byte = {settings_q.inversion_sel, settings_q.frame_rate_sel};
         4'h3: entry_byte = {settings_q.display_on, 5'b00000, settings_q.mirror, 1'b0};
         4'h4: entry_byte = {3'b000, settings_q.pump_enable, 1'b0,
                             settings_q.multiplier_sel, settings_q.lcd_voltage_value[8]};
         4'h5: entry_byte = settings_q.lcd_voltage_value[7:0];
         4'h6: entry_byte = {settings_q.tempcomp_enable, settings_q.measure_filter,
                             settings_q.slope_a, settings_q.slope_b};
         4'h7: entry_byte = {settings_q.measure_enable, settings_q.slope_c, settings_q.slope_d, 1'b0};
         4'h8: entry_byte = 8'h00;
         4'h9: entry_byte = {5'b00000, pump_reached_q, flag_q, settings_q.clock_out_enable};
         default: entry_byte = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         entry_q <= '0;
      else if (frame_start || do_init)
         entry_q <= '0;
      else if (do_read_status && settings_q.readout_status)
         entry_q <= (entry_q == `LAST_ENTRY) ? 4'h0 : (entry_q + 4'h1);
   end

   // ===================================================
   // read answers, one cycle after the request
   logic [7:0] ram_rd;
   logic rd_valid_q;
   logic [7:0] rd_data_q;

   always_comb
   begin
      case (settings_q.bank_sel)
         3'h0: ram_rd = ram_wide_q[addr_q];
         3'h1: ram_rd = {3'b000, narrow_rd[0]};
         3'h2: ram_rd = {3'b000, narrow_rd[1]};
         3'h3: ram_rd = {3'b000, narrow_rd[2]};
         3'h4: ram_rd = {3'b000, narrow_rd[3]};
         default: ram_rd = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rd_valid_q <= 1'b0;
         rd_data_q <= 8'h00;
      end
      else
      begin
         rd_valid_q <= cmd_valid && cmd.rw;
         if (do_read_status)
            rd_data_q <= settings_q.readout_status ? entry_byte : temperature_value;
         else if (do_read_data)
            rd_data_q <= ram_rd;
         else if (cmd_valid && cmd.rw)
            rd_data_q <= 8'h00;
      end
   end

   // ===================================================
   // outputs
   assign rd_valid = rd_valid_q;
   assign rd_data = rd_data_q;
   assign settings = settings_q;
   assign ram_addr = addr_q;
   assign reset_seen_flag = flag_q;

endmodule : lcd_status_and_ram_access

`default_nettype wire

/* verif/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// host side: one command byte per transfer
module host_model
   import lcd_cmd_pkg::*;
(
   input wire logic mclk,
   input wire logic [7:0] rd_data,
   output logic frame_start,
   output logic cmd_valid,
   output cmd_t cmd
);
   logic [2:0] bank_q;
   initial
   begin
      frame_start = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      bank_q = 3'h0;
   end
   task automatic xfer(input logic rw, input logic [1:0] grp, input logic [7:0] data, output logic [7:0] q);
      @(posedge mclk);
      #1;
      if (grp == 2'h1 && !rw && bank_q != 3'h0) data[7:5] = 3'h0;
      if (grp == 2'h0 && !rw && data[7:3] == 5'h02) bank_q = data[2:0];
      // init puts the device back on the wide general ram
      if (grp == 2'h0 && !rw && data == 8'h01) bank_q = 3'h0;
      cmd_valid = 1'b1;
      cmd = {rw, grp, data};
      @(posedge mclk);
      #1;
      cmd_valid = 1'b0;
      // released lines show the inverse of the last byte
      cmd = ~cmd;
      q = rd_data;
   endtask : xfer
   task automatic new_frame;
      @(posedge mclk);
      #1;
      frame_start = 1'b1;
      @(posedge mclk);
      #1;
      frame_start = 1'b0;
   endtask : new_frame
endmodule : host_model
`default_nettype wire

/* verif/lcd_cmd_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ==================================================
// port checks of the command decoder
module lcd_cmd_sva
   import lcd_cmd_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic frame_start,
   input wire logic cmd_valid,
   input wire cmd_t cmd,
   input wire logic [7:0] temperature_value,
   input wire logic pump_reached_pin,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   input wire settings_t settings,
   input wire logic [6:0] ram_addr,
   input wire logic reset_seen_flag
);
   logic gen_wr;
   logic acc;
   assign gen_wr = cmd_valid && !cmd.rw && cmd.command_group == 2'h0;
   assign acc = cmd_valid && cmd.command_group == 2'h1 && settings.bank_sel <= 3'h4;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   chk_read_answer: assert property (cmd_valid && cmd.rw |=> rd_valid)
      else $error("read not answered");
   chk_no_stray: assert property (!(cmd_valid && cmd.rw) |=> !rd_valid)
      else $error("answer without read");
   chk_temp_read: assert property (cmd_valid && cmd.rw && cmd.command_group == 2'h0 &&
      !settings.readout_status |=> rd_data == $past(temperature_value)) else $error("bad temperature");
   chk_addr_load: assert property (gen_wr && cmd.data[7] |=> ram_addr == $past(cmd.data[6:0]))
      else $error("address not loaded");
   chk_addr_step: assert property (acc |=> ram_addr ==
      ($past(settings.step_up) ? $past(ram_addr) + 7'h1 : $past(ram_addr) - 7'h1)) else $error("bad step");
   chk_read_mask: assert property (acc && cmd.rw && settings.bank_sel != 3'h0 ##1 rd_valid
      |-> rd_data[7:5] == 3'h0) else $error("upper bits not zero");
   chk_mux_cmd: assert property (gen_wr && cmd.data[7:3] == 5'h0a
      |=> settings.mux_ratio_sel == $past(cmd.data[2])) else $error("mux mode not taken");
   chk_bank_cmd: assert property (gen_wr && cmd.data[7:3] == 5'h02 && cmd.data[2:0] <= 3'h4
      |=> settings.bank_sel == $past(cmd.data[2:0])) else $error("bank not taken");
   chk_select_cmd: assert property (gen_wr && cmd.data[7:2] == 6'h01
      |=> {settings.sum_kind, settings.readout_status} == $past(cmd.data[1:0])) else $error("select not taken");
   chk_flag_clear: assert property (gen_wr && cmd.data == 8'h1f |=> !reset_seen_flag)
      else $error("flag not cleared");
   chk_flag_hold: assert property (!reset_seen_flag && !(gen_wr && cmd.data == 8'h01)
      |=> !reset_seen_flag) else $error("flag set without reset");
   cover property (rd_valid && settings.readout_status);
   cover property (acc && !cmd.rw);
   cover property ($fell(reset_seen_flag));
endmodule : lcd_cmd_sva
bind lcd_status_and_ram_access lcd_cmd_sva i_sva (.mclk(mclk), .rst(rst), .frame_start(frame_start),
   .cmd_valid(cmd_valid), .cmd(cmd), .temperature_value(temperature_value), .pump_reached_pin(pump_reached_pin),
   .rd_valid(rd_valid), .rd_data(rd_data), .settings(settings), .ram_addr(ram_addr),
   .reset_seen_flag(reset_seen_flag));
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import lcd_cmd_pkg::*;
   logic mclk, rst, frame_start, cmd_valid, pump_reached_pin, rd_valid, reset_seen_flag;
   logic [7:0] temperature_value, rd_data, q;
   logic [6:0] ram_addr;
   cmd_t cmd;
   settings_t settings;
   int err_total = 0;
   int checks = 0;
   int cycles = 0;
   logic [9:0] cfg [16] = '{10'h050, 10'h01f, 10'h245, 10'h29f, 10'h224, 10'h206, 10'h386, 10'h3b1,
      10'h395, 10'h307, 10'h30d, 10'h312, 10'h31b, 10'h326, 10'h021, 10'h005};
   initial mclk = 1'b0;
   always #10 mclk = ~mclk;
   lcd_status_and_ram_access i_dut (.mclk(mclk), .rst(rst), .frame_start(frame_start), .cmd_valid(cmd_valid),
      .cmd(cmd), .temperature_value(temperature_value), .pump_reached_pin(pump_reached_pin),
      .rd_valid(rd_valid), .rd_data(rd_data), .settings(settings), .ram_addr(ram_addr),
      .reset_seen_flag(reset_seen_flag));
   host_model i_host (.mclk(mclk), .rd_data(rd_data), .frame_start(frame_start), .cmd_valid(cmd_valid),
      .cmd(cmd));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_of_test;
      if (err_total == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [1:0] grp, input logic [7:0] data);
      i_host.xfer(1'b0, grp, data, q);
   endtask : wr
   task automatic status_walk(input logic [79:0] exp);
      i_host.new_frame();
      for (int i = 0; i < 10; i++)
      begin
         i_host.xfer(1'b1, 2'h0, 8'h00, q);
         check("status", q, exp[8*(9-i) +: 8]);
         check("status valid", {7'h0, rd_valid}, 8'h01);
      end
   endtask : status_walk
   task automatic t_defaults;
      i_host.xfer(1'b1, 2'h0, 8'h00, q);
      check("temperature", q, 8'h5a);
      wr(2'h0, 8'h05);
      status_walk({8'h00, 8'h48, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02});
      i_host.xfer(1'b1, 2'h0, 8'h00, q);
      check("wrap", q, 8'h00);
      check("flag", {7'h0, reset_seen_flag}, 8'h01);
   endtask : t_defaults
   task automatic t_ram;
      wr(2'h0, 8'hff);
      wr(2'h1, 8'ha5);
      wr(2'h1, 8'h3c);
      check("addr up", {1'b0, ram_addr}, 8'h01);
      wr(2'h0, 8'hff);
      i_host.xfer(1'b1, 2'h1, 8'h00, q);
      check("gp1 read", q, 8'ha5);
      i_host.xfer(1'b1, 2'h1, 8'h00, q);
      check("gp1 next", q, 8'h3c);
      wr(2'h2, 8'h28);
      wr(2'h0, 8'h11);
      check("bank", {5'h0, settings.bank_sel}, 8'h01);
      wr(2'h0, 8'h90);
      wr(2'h1, 8'h15);
      wr(2'h1, 8'h0a);
      check("addr down", {1'b0, ram_addr}, 8'h0e);
      wr(2'h0, 8'h90);
      i_host.xfer(1'b1, 2'h1, 8'h00, q);
      check("bank read", q, 8'h15);
      i_host.xfer(1'b1, 2'h1, 8'h00, q);
      check("bank next", q, 8'h0a);
   endtask : t_ram
   task automatic t_settings;
      pump_reached_pin = 1'b1;
      foreach (cfg[i]) wr(cfg[i][9:8], cfg[i][7:0]);
      check("mux", {7'h0, settings.mux_ratio_sel}, 8'h00);
      status_walk({8'h86, 8'h00, 8'hbf, 8'h82, 8'h15, 8'h15, 8'hea, 8'hbc, 8'h00, 8'h05});
   endtask : t_settings
   task automatic t_init;
      wr(2'h0, 8'h01);
      check("init flag", {7'h0, reset_seen_flag}, 8'h01);
      check("init addr", {1'b0, ram_addr}, 8'h00);
      i_host.xfer(1'b1, 2'h0, 8'h00, q);
      check("init temperature", q, 8'h5a);
      // crc kind and status readout, then two writes: crc8 of 01, 02 from zero is 1b
      wr(2'h0, 8'h07);
      wr(2'h1, 8'h01);
      wr(2'h1, 8'h02);
      status_walk({8'h1b, 8'h48, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06});
   endtask : t_init
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_total++;
         end_of_test();
      end
   end
   initial
   begin
      rst = 1'b1;
      temperature_value = 8'h5a;
      pump_reached_pin = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      rst = 1'b0;
      t_defaults();
      t_ram();
      t_settings();
      t_init();
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
